// *** hw/saw_pkg.sv ***
package saw_pkg;
  // ****************************************************************
  // Frame format and reset values
  // ****************************************************************
  localparam int unsigned DATA_W      = 8;
  localparam logic [7:0]  DUMMY_BYTE  = 8'h00;
  localparam logic [7:0]  RESET_BYTE  = 8'h00;
  // Bit time in reference clock cycles
  localparam int unsigned BIT_CYCLES  = 16;
  localparam int unsigned HALF_CYCLES = BIT_CYCLES / 2;
  localparam int unsigned CNT_W       = 5;
  localparam int unsigned BIT_CNT_W   = 4;
  localparam logic [3:0]  LAST_BIT    = 4'h8;
  localparam int unsigned BUF_DEPTH   = 2;
endpackage : saw_pkg

// *** hw/saw_rx_buffer.sv ***
`timescale 1ns/1ps
// ****************************************************************
// Two-entry buffer between the receiver and the reader
// ****************************************************************
module saw_rx_buffer
  import saw_pkg::*;
(
  input  wire logic              ref_clk,
  input  wire logic              rstn,
  input  wire logic              inValid,
  output logic                   inReady,
  input  wire logic [DATA_W-1:0] inData,
  output logic                   outValid,
  input  wire logic              outReady,
  output logic [DATA_W-1:0]      outData
);
  typedef struct packed {
    logic [1:0][DATA_W-1:0] mem;
    logic                   wrPtr;
    logic                   rdPtr;
    logic [1:0]             count;
  } saw_buf_state_t;

  saw_buf_state_t stateQ;
  saw_buf_state_t stateD;
  logic           push;
  logic           pop;

  // Full and empty come straight from the occupancy count
  assign inReady  = (stateQ.count != 2'(BUF_DEPTH));
  assign outValid = (stateQ.count != 2'h0);
  assign outData  = stateQ.mem[stateQ.rdPtr];
  assign push     = inValid && inReady;
  assign pop      = outValid && outReady;

  // Next state of pointers and storage
  always_comb begin
    stateD = stateQ;
    if (push) begin
      stateD.mem[stateQ.wrPtr] = inData;
      stateD.wrPtr             = ~stateQ.wrPtr;
    end
    if (pop) begin
      stateD.rdPtr = ~stateQ.rdPtr;
    end
    if (push && !pop) begin
      stateD.count = stateQ.count + 2'h1;
    end else if (pop && !push) begin
      stateD.count = stateQ.count - 2'h1;
    end
  end

  // Register the state
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      stateQ <= '0;
    end else begin
      stateQ <= stateD;
    end
  end
endmodule : saw_rx_buffer

// *** hw/saw_rx_wake.sv ***
`timescale 1ns/1ps
// What this block does
// - Setting the arm bit parks the receiver idle, watching the line.
// - While armed, a rising edge on the receive pin is the wake cue.
// - The wake event sets the receive interrupt flag.
// - The arm bit clears itself at that rising edge; reception resumes.
// - The self-cleared arm bit tells software the break is over.
// - Reading the data register clears the receive interrupt once no other word waits.
module saw_rx_wake
  import saw_pkg::*;
(
  input  wire logic              ref_clk,
  input  wire logic              rstn,
  input  wire logic              rxLinePin,
  input  wire logic              armSet,
  output logic                   wakeArmBit,
  output logic                   rxIdleStatus,
  output logic                   rxInterruptFlag,
  input  wire logic              rxDataRead,
  output logic [DATA_W-1:0]      rxDataRegister,
  output logic                   frameError
);
  // ****************************************************************
  // State
  // ****************************************************************
  typedef enum logic [1:0] {SAW_IDLE, SAW_START, SAW_DATA, SAW_STOP} saw_rx_st_t;

  typedef struct packed {
    saw_rx_st_t          st;
    logic                arm;
    logic                lineLast;
    logic [CNT_W-1:0]    cnt;
    logic [BIT_CNT_W-1:0] bitIdx;
    logic [DATA_W-1:0]   shift;
    logic                pushReq;
    logic [DATA_W-1:0]   pushData;
    logic                ferr;
  } saw_state_t;

  saw_state_t stateQ;
  saw_state_t stateD;
  logic       riseEdge;
  logic       fallEdge;
  logic       bufReady;

  // ****************************************************************
  // Decode helpers
  // ****************************************************************
  // Last clock of a full bit time; data and stop bits share this decode
  function automatic logic bitEnd(input logic [CNT_W-1:0] c);
    return c == CNT_W'(BIT_CYCLES - 1);
  endfunction : bitEnd

  // Line is synchronous by system contract, so edges are taken directly
  assign riseEdge = rxLinePin && !stateQ.lineLast;
  assign fallEdge = !rxLinePin && stateQ.lineLast;

  // ****************************************************************
  // Receiver and wake control
  // ****************************************************************
  always_comb begin
    stateD          = stateQ;
    stateD.lineLast = rxLinePin;
    if (stateQ.pushReq && bufReady) begin
      stateD.pushReq = 1'b0;
    end
    if (stateQ.arm) begin
      stateD.st = SAW_IDLE;
      // A rising edge ends the break: disarm and post the dummy byte
      if (riseEdge) begin
        stateD.arm      = 1'b0;
        stateD.pushReq  = 1'b1;
        stateD.pushData = DUMMY_BYTE;
      end
    end else begin
      // A stalled word would otherwise slip into the register behind the arm bit
      if (armSet && stateQ.st == SAW_IDLE && (!stateQ.pushReq || bufReady)) begin
        stateD.arm = 1'b1;
      end
      case (stateQ.st)
        // Wait for the falling edge that opens a frame
        SAW_IDLE: begin
          if (fallEdge && !armSet) begin
            stateD.st  = SAW_START;
            stateD.cnt = '0;
          end
        end
        // Half a bit in, confirm that the start bit is still low
        SAW_START: begin
          stateD.cnt = stateQ.cnt + 1'b1;
          if (stateQ.cnt == CNT_W'(HALF_CYCLES - 1)) begin
            stateD.cnt    = '0;
            stateD.bitIdx = '0;
            // A glitch that is high at mid start bit is dropped
            stateD.st     = rxLinePin ? SAW_IDLE : SAW_DATA;
          end
        end
        // Data bits arrive LSB first, each taken near its middle
        SAW_DATA: begin
          stateD.cnt = stateQ.cnt + 1'b1;
          if (bitEnd(stateQ.cnt)) begin
            stateD.cnt    = '0;
            stateD.shift  = {rxLinePin, stateQ.shift[DATA_W-1:1]};
            stateD.bitIdx = stateQ.bitIdx + 1'b1;
            if (stateQ.bitIdx == LAST_BIT - 4'h1) begin
              stateD.st = SAW_STOP;
            end
          end
        end
        // A low stop bit marks a framing fault; the word is posted anyway
        SAW_STOP: begin
          stateD.cnt = stateQ.cnt + 1'b1;
          if (bitEnd(stateQ.cnt)) begin
            stateD.st       = SAW_IDLE;
            stateD.ferr     = !rxLinePin;
            // Pending word is overwritten if the buffer is still full when this word ends
            stateD.pushReq  = 1'b1;
            stateD.pushData = stateQ.shift;
          end
        end
        default: stateD.st = SAW_IDLE;
      endcase
    end
  end

  // Line sampler resets high, the idle level, so no false edge follows reset
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      stateQ          <= '0;
      stateQ.lineLast <= 1'b1;
      stateQ.st       <= SAW_IDLE;
    end else begin
      stateQ <= stateD;
    end
  end

  // ****************************************************************
  // Data register buffer; a read pops one word
  // ****************************************************************
  logic              bufValid;
  logic [DATA_W-1:0] bufData;

  saw_rx_buffer uBuf (
    .ref_clk  (ref_clk),
    .rstn     (rstn),
    .inValid  (stateQ.pushReq),
    .inReady  (bufReady),
    .inData   (stateQ.pushData),
    .outValid (bufValid),
    .outReady (rxDataRead),
    .outData  (bufData)
  );

  // Flag follows buffer content, so a read clears it unless more waits
  assign rxInterruptFlag = bufValid;
  assign rxDataRegister  = bufData;
  assign wakeArmBit      = stateQ.arm;
  assign rxIdleStatus    = (stateQ.st == SAW_IDLE) && !stateQ.arm;
  assign frameError      = stateQ.ferr;

  // ****************************************************************
  // Checks
  // ****************************************************************
  // Wake cue: a rise on the line while armed
  sequence armedRise;
    stateQ.arm && riseEdge;
  endsequence

  // The fall that opens a break while armed
  sequence armedFall;
    stateQ.arm && fallEdge;
  endsequence

  // The dummy word stands at the head of the data register
  sequence dummyPosted;
    rxInterruptFlag && rxDataRegister == DUMMY_BYTE;
  endsequence

  // Arming is taken only from a quiet receiver with nothing stalled
  AST_ARM_TAKE: assert property (@(posedge ref_clk) disable iff (!rstn)
    armSet && !stateQ.arm && stateQ.st == SAW_IDLE && (!stateQ.pushReq || bufReady)
    |=> wakeArmBit) else $error("arm not taken");
  AST_ARM_BUSY: assert property (@(posedge ref_clk) disable iff (!rstn)
    armSet && !stateQ.arm && stateQ.st != SAW_IDLE |=> !wakeArmBit)
    else $error("armed while busy");
  AST_ARM_IDLE: assert property (@(posedge ref_clk) disable iff (!rstn)
    wakeArmBit |-> stateQ.st == SAW_IDLE) else $error("armed busy");
  AST_ARM_HOLD: assert property (@(posedge ref_clk) disable iff (!rstn)
    stateQ.arm && !riseEdge |=> wakeArmBit) else $error("arm lost");
  AST_BREAK_HOLD: assert property (@(posedge ref_clk) disable iff (!rstn)
    armedFall |=> wakeArmBit && !rxIdleStatus) else $error("break ended wait");

  // Wake edge: disarm at once, then the dummy word raises the flag
  AST_WAKE_DISARM: assert property (@(posedge ref_clk) disable iff (!rstn)
    armedRise |=> !wakeArmBit) else $error("arm bit did not clear");
  AST_WAKE_RESUME: assert property (@(posedge ref_clk) disable iff (!rstn)
    armedRise |=> rxIdleStatus) else $error("receiver not back after wake");
  AST_WAKE_FLAG: assert property (@(posedge ref_clk) disable iff (!rstn)
    armedRise |-> ##[1:3] rxInterruptFlag) else $error("no wake flag");
  AST_WAKE_DUMMY: assert property (@(posedge ref_clk) disable iff (!rstn)
    armedRise ##0 (!rxInterruptFlag && !stateQ.pushReq) |-> ##2 dummyPosted)
    else $error("wake word missing");

  // Nothing but the dummy word may reach the data register while armed
  AST_ARMED_DUMMY: assert property (@(posedge ref_clk) disable iff (!rstn)
    stateQ.pushReq && stateQ.pushData != DUMMY_BYTE |-> !stateQ.arm)
    else $error("real data while armed");
  AST_ARMED_QUIET: assert property (@(posedge ref_clk) disable iff (!rstn)
    stateQ.arm |=> $stable(stateQ.shift) && $stable(frameError))
    else $error("receiver moved while armed");
  // A read of the last waiting word drops the flag
  AST_READ_CLEAR: assert property (@(posedge ref_clk) disable iff (!rstn)
    rxDataRead && rxInterruptFlag && bufReady && !stateQ.pushReq |=> !rxInterruptFlag)
    else $error("read left flag");
endmodule : saw_rx_wake

// *** test/saw_remote_tx.sv ***
`timescale 1ns/1ps
// ****************************************************************
// Remote serial transmitter model
// ****************************************************************
module saw_remote_tx
  import saw_pkg::*;
(
  input  wire logic ref_clk,
  output logic      rxLinePin
);
  // Line idles high; every change lands on a falling edge
  initial rxLinePin = 1'b1;

  // One level for a whole number of bit times
  task automatic hold_bits(input logic lvl, input int nBits);
    rxLinePin = lvl;
    repeat (nBits * BIT_CYCLES) @(negedge ref_clk);
  endtask : hold_bits

  // LSB first; a low stop bit is the only fault a test may command
  task automatic send_byte(input logic [DATA_W-1:0] b, input logic stopBit);
    hold_bits(1'b0, 1);
    for (int i = 0; i < DATA_W; i++) hold_bits(b[i], 1);
    hold_bits(stopBit, 1);
    hold_bits(1'b1, 1);
  endtask : send_byte
endmodule : saw_remote_tx

// *** test/serial_rx_auto_wakeup_test.sv ***
`timescale 1ns/1ps
// ****************************************************************
// Bench for the wake-up receiver
// ****************************************************************
module serial_rx_auto_wakeup_test;
  import saw_pkg::*;
  logic              ref_clk = 1'b0;
  logic              rstn = 1'b0;
  logic              armSet = 1'b0;
  logic              rxDataRead = 1'b0;
  logic              rxLinePin, wakeArmBit, rxIdleStatus, rxInterruptFlag, frameError;
  logic [DATA_W-1:0] rxDataRegister;
  int                n_mismatch = 0;
  int                check_count = 0;

  // 40 MHz reference clock
  always #12.5 ref_clk = ~ref_clk;

  saw_remote_tx remote (.ref_clk(ref_clk), .rxLinePin(rxLinePin));
  saw_rx_wake DUT (.ref_clk(ref_clk), .rstn(rstn), .rxLinePin(rxLinePin), .armSet(armSet),
    .wakeArmBit(wakeArmBit), .rxIdleStatus(rxIdleStatus), .rxInterruptFlag(rxInterruptFlag),
    .rxDataRead(rxDataRead), .rxDataRegister(rxDataRegister), .frameError(frameError));

  // Four-state compare so an unknown never matches
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  // One-cycle strobe on read (1) or arm (0), launched and dropped on falling edges
  task automatic pulse(input bit isRead);
    if (isRead) rxDataRead = 1'b1;
    else armSet = 1'b1;
    @(negedge ref_clk);
    rxDataRead = 1'b0;
    armSet = 1'b0;
    @(negedge ref_clk);
  endtask : pulse

  // Flag must stand with the expected head word before it is popped
  task automatic read_word(input logic [7:0] exp);
    check({7'h00, rxInterruptFlag}, 8'h01);
    check(rxDataRegister, exp);
    pulse(1'b1);
  endtask : read_word

  task automatic test_reset();
    check({7'h00, wakeArmBit}, 8'h00);
    check({7'h00, rxInterruptFlag}, 8'h00);
    check(rxDataRegister, RESET_BYTE);
    check({7'h00, rxIdleStatus}, 8'h01);
    $display("test_reset done");
  endtask : test_reset

  // Break of twelve zero bits, then the rise that ends it
  task automatic test_wake();
    pulse(1'b0);
    check({7'h00, wakeArmBit}, 8'h01);
    check({7'h00, rxIdleStatus}, 8'h00);
    remote.hold_bits(1'b0, 12);
    check({7'h00, rxInterruptFlag}, 8'h00);
    check({7'h00, frameError}, 8'h00);
    check({7'h00, wakeArmBit}, 8'h01);
    remote.hold_bits(1'b1, 2);
    check({7'h00, wakeArmBit}, 8'h00);
    read_word(DUMMY_BYTE);
    check({7'h00, rxInterruptFlag}, 8'h00);
    remote.send_byte(8'h5A, 1'b1);
    read_word(8'h5A);
    $display("test_wake done");
  endtask : test_wake

  // Arming in mid-frame is ignored and the word still arrives
  task automatic test_busy_arm();
    fork
      remote.send_byte(8'h81, 1'b1);
      begin
        repeat (40) @(negedge ref_clk);
        check({7'h00, rxIdleStatus}, 8'h00);
        pulse(1'b0);
        check({7'h00, wakeArmBit}, 8'h00);
      end
    join
    read_word(8'h81);
    $display("test_busy_arm done");
  endtask : test_busy_arm

  // Two words held unread keep their order; a low stop bit is flagged
  task automatic test_buffer();
    remote.send_byte(8'h12, 1'b1);
    remote.send_byte(8'h34, 1'b1);
    read_word(8'h12);
    read_word(8'h34);
    check({7'h00, frameError}, 8'h00);
    remote.send_byte(8'hC3, 1'b0);
    check({7'h00, frameError}, 8'h01);
    read_word(8'hC3);
    $display("test_buffer done");
  endtask : test_buffer

  task automatic print_verdict();
    $display("Counts: %0d checks, %0d mismatches", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : print_verdict

  // Main sequence after five reset cycles
  initial begin
    repeat (5) @(negedge ref_clk);
    rstn = 1'b1;
    @(negedge ref_clk);
    test_reset();
    test_wake();
    test_busy_arm();
    test_buffer();
    print_verdict();
  end

  // Tests need about 1100 cycles; eighteen times that means a hang
  initial begin
    repeat (20000) @(posedge ref_clk);
    n_mismatch++;
    print_verdict();
  end
endmodule : serial_rx_auto_wakeup_test
